// >>> verilog/tmrb_pkg.sv
// Package: constants and types of the compare-B timer slice
// Contract
// [RQ1] 8-bit constant B per channel, pair as word
// [RQ2] Equal to counter sets match B flag
// [RQ3] No comparison during constant B write cycle
// [RQ4] Match B plus output select drives pin
// [RQ5] Constant B resets to all ones
// [RQ6] Control picks clock, clear event, interrupts
// [RQ7] Bit 7 gates match B interrupt request
// [RQ8] Bit 6 gates match A interrupt request
// [RQ9] Bit 5 gates overflow interrupt request
// [RQ10] Request held while flag and enable set
package tmrb_pkg;

  typedef logic [7:0] tmrb_byte_t;

  // Word register indices on the plain register port
  localparam logic [1:0] ADDR_TCB = 2'h0;
  localparam logic [1:0] ADDR_CTL = 2'h1;
  localparam logic [1:0] ADDR_CSR = 2'h2;

  // Reset values
  localparam tmrb_byte_t TCB_RESET = 8'hFF;
  localparam tmrb_byte_t CTL_RESET = 8'h00;
  localparam tmrb_byte_t CSR_RESET = 8'h00;
  localparam logic       PIN_RESET = 1'b0;

  // Timer control fields
  localparam int CTL_IE_B      = 7;
  localparam int CTL_IE_A      = 6;
  localparam int CTL_IE_OV     = 5;
  localparam int CTL_CLR_LSB   = 3;
  localparam int CTL_CLR_WIDTH = 2;
  localparam int CTL_CKS_LSB   = 0;
  localparam int CTL_CKS_WIDTH = 3;

  // Control/status fields
  localparam int CSR_FLAG_B  = 7;
  localparam int CSR_FLAG_A  = 6;
  localparam int CSR_FLAG_OV = 5;
  localparam int CSR_OS_LSB  = 0;

  // Output select codes
  localparam logic [1:0] OS_KEEP   = 2'h0;
  localparam logic [1:0] OS_LOW    = 2'h1;
  localparam logic [1:0] OS_HIGH   = 2'h2;
  localparam logic [1:0] OS_TOGGLE = 2'h3;

endpackage : tmrb_pkg

// >>> verilog/tmrb_match_if.sv
// Interface: compare-match B and output select between compare and pin logic
`timescale 1ns/100ps
interface tmrb_match_if;
  logic       matchB;
  logic [1:0] outputSelect;
  modport producer (output matchB);
  modport consumer (input matchB, input outputSelect);
endinterface : tmrb_match_if

// >>> verilog/tmrb_compare.sv
// Module: continual compare of constant B against the counter value
`timescale 1ns/100ps
module tmrb_compare (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  counterValue,
  input  wire logic [7:0]  timeConstB,
  input  wire logic        suppress,
  tmrb_match_if.producer   cmp
);

  logic matchB_q;
  logic matchB_d;

  always_comb begin
    matchB_d = (counterValue == timeConstB) && !suppress; // [RQ2] [RQ3]
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      matchB_q <= 1'b0;
    end else begin
      matchB_q <= matchB_d;
    end
  end

  assign cmp.matchB = matchB_q;

  sequence equalSeen;
    (counterValue == timeConstB) && !suppress;
  endsequence

  property matchFollows;
    @(posedge clk) disable iff (!resetn) equalSeen |=> cmp.matchB;
  endproperty

  matchOnEqual_a : assert property (matchFollows) // [RQ2]
    else $error("match B missing one cycle after equality");

  writeSuppress_a : assert property ( // [RQ3]
    @(posedge clk) disable iff (!resetn) suppress |=> !cmp.matchB)
    else $error("match B raised during a constant B write");

endmodule : tmrb_compare

// >>> verilog/tmrb_out_ctl.sv
// Module: timer output pin driven by match B and output select
`timescale 1ns/100ps
module tmrb_out_ctl (
  input  wire logic        clk,
  input  wire logic        resetn,
  tmrb_match_if.consumer   mif,
  output logic             pinLevel
);

  logic pin_q;
  logic pin_d;

  always_comb begin
    pin_d = pin_q;
    if (mif.matchB) begin
      case (mif.outputSelect) // [RQ4]
        tmrb_pkg::OS_LOW:    pin_d = 1'b0;
        tmrb_pkg::OS_HIGH:   pin_d = 1'b1;
        tmrb_pkg::OS_TOGGLE: pin_d = !pin_q;
        default:             pin_d = pin_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_q <= tmrb_pkg::PIN_RESET;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign pinLevel = pin_q;

  pinSet_a : assert property ( // [RQ4]
    @(posedge clk) disable iff (!resetn)
    mif.matchB && (mif.outputSelect == tmrb_pkg::OS_HIGH) |=> pinLevel)
    else $error("pin not high after match with select high");

  pinToggle_a : assert property ( // [RQ4]
    @(posedge clk) disable iff (!resetn)
    mif.matchB && (mif.outputSelect == tmrb_pkg::OS_TOGGLE) |=> pinLevel != $past(pinLevel))
    else $error("pin did not toggle on match");

  pinHold_a : assert property ( // [RQ4]
    @(posedge clk) disable iff (!resetn)
    !mif.matchB |=> $stable(pinLevel))
    else $error("pin changed without a match");

endmodule : tmrb_out_ctl

// >>> verilog/tmrb_top.sv
// Module: two-channel constant B compare, control register and interrupt gating
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
module tmrb_top (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [1:0]       regAddr,
  input  wire logic [1:0]       regByteEn,
  input  wire logic [15:0]      regWrData,
  input  wire logic             regWrite,
  input  wire logic             regRead,
  output logic      [15:0]      regRdData,
  input  wire logic [15:0]      timerCounterValue,
  input  wire logic [1:0]       matchAEvent,
  input  wire logic [1:0]       overflowEvent,
  output logic      [1:0]       timerOutputPin,
  output logic      [1:0][2:0]  counterClockSelect,
  output logic      [1:0][1:0]  counterClearSelect,
  output logic      [1:0]       matchBIrq,
  output logic      [1:0]       matchAIrq,
  output logic      [1:0]       overflowIrq
);

  // Lane 1 (high byte) is the even channel, lane 0 the odd one,
  // so a word access reaches both halves of the pair at once.

  logic [1:0][7:0] tcb_q;
  logic [1:0][7:0] tcb_d;
  logic [1:0][7:0] ctl_q;
  logic [1:0][7:0] ctl_d;
  logic [1:0][7:0] csr_q;
  logic [1:0][7:0] csr_d;
  logic [15:0]     rdData_q;
  logic [15:0]     rdData_d;
  logic [1:0]      irqB_q;
  logic [1:0]      irqB_d;
  logic [1:0]      irqA_q;
  logic [1:0]      irqA_d;
  logic [1:0]      irqOv_q;
  logic [1:0]      irqOv_d;
  wire logic [1:0] matchB;
  wire logic [1:0] tcbWrite;
  wire logic [1:0] pinLevel;
  logic            tcbWritten_q;
  logic            tcbWritten_d;

  function automatic logic laneWrite(
    input logic       wr,
    input logic [1:0] addr,
    input logic [1:0] be,
    input logic [1:0] target,
    input int         lane
  );
    return wr && (addr == target) && be[lane];
  endfunction : laneWrite

  // Per-lane compare and pin logic
  for (genvar l = 0; l < 2; l++) begin : g_lane
    tmrb_match_if mif ();

    assign tcbWrite[l] = laneWrite(regWrite, regAddr, regByteEn, tmrb_pkg::ADDR_TCB, l);
    assign mif.outputSelect = csr_q[l][tmrb_pkg::CSR_OS_LSB +: 2];
    assign matchB[l] = mif.matchB;

    tmrb_compare u_compare (
      .clk          (clk),
      .resetn       (resetn),
      .counterValue (timerCounterValue[8*l +: 8]),
      .timeConstB   (tcb_q[l]),
      .suppress     (tcbWrite[l]),
      .cmp          (mif)
    );

    tmrb_out_ctl u_out (
      .clk      (clk),
      .resetn   (resetn),
      .mif      (mif),
      .pinLevel (pinLevel[l])
    );
  end

  always_comb begin
    tcb_d        = tcb_q;
    ctl_d        = ctl_q;
    csr_d        = csr_q;
    irqB_d       = 2'h0;
    irqA_d       = 2'h0;
    irqOv_d      = 2'h0;
    rdData_d     = 16'h0000;
    tcbWritten_d = tcbWritten_q || (|tcbWrite);
    for (int l = 0; l < 2; l++) begin
      if (tcbWrite[l]) begin
        tcb_d[l] = regWrData[8*l +: 8]; // [RQ1]
      end
      if (laneWrite(regWrite, regAddr, regByteEn, tmrb_pkg::ADDR_CTL, l)) begin
        ctl_d[l] = regWrData[8*l +: 8]; // [RQ6]
      end
      if (laneWrite(regWrite, regAddr, regByteEn, tmrb_pkg::ADDR_CSR, l)) begin
        // Flags are only cleared by writing 0; a written 1 is ignored
        csr_d[l][tmrb_pkg::CSR_FLAG_B] =
          csr_q[l][tmrb_pkg::CSR_FLAG_B] & regWrData[8*l + tmrb_pkg::CSR_FLAG_B];
        csr_d[l][tmrb_pkg::CSR_FLAG_A] =
          csr_q[l][tmrb_pkg::CSR_FLAG_A] & regWrData[8*l + tmrb_pkg::CSR_FLAG_A];
        csr_d[l][tmrb_pkg::CSR_FLAG_OV] =
          csr_q[l][tmrb_pkg::CSR_FLAG_OV] & regWrData[8*l + tmrb_pkg::CSR_FLAG_OV];
        csr_d[l][tmrb_pkg::CSR_OS_LSB +: 2] = regWrData[8*l + tmrb_pkg::CSR_OS_LSB +: 2];
      end
      // Setting wins over a clearing write in the same cycle
      if (matchB[l]) begin
        csr_d[l][tmrb_pkg::CSR_FLAG_B] = 1'b1; // [RQ2]
      end
      if (matchAEvent[l]) begin
        csr_d[l][tmrb_pkg::CSR_FLAG_A] = 1'b1;
      end
      if (overflowEvent[l]) begin
        csr_d[l][tmrb_pkg::CSR_FLAG_OV] = 1'b1;
      end
      // Requests follow flag and enable as levels
      irqB_d[l]  = csr_d[l][tmrb_pkg::CSR_FLAG_B] & ctl_d[l][tmrb_pkg::CTL_IE_B]; // [RQ7] [RQ10]
      irqA_d[l]  = csr_d[l][tmrb_pkg::CSR_FLAG_A] & ctl_d[l][tmrb_pkg::CTL_IE_A]; // [RQ8] [RQ10]
      irqOv_d[l] = csr_d[l][tmrb_pkg::CSR_FLAG_OV] & ctl_d[l][tmrb_pkg::CTL_IE_OV]; // [RQ9] [RQ10]
    end
    if (regRead) begin
      case (regAddr)
        tmrb_pkg::ADDR_TCB: rdData_d = tcb_q; // [RQ1]
        tmrb_pkg::ADDR_CTL: rdData_d = ctl_q;
        tmrb_pkg::ADDR_CSR: rdData_d = csr_q;
        default:            rdData_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tcb_q        <= {2{tmrb_pkg::TCB_RESET}}; // [RQ5]
      ctl_q        <= {2{tmrb_pkg::CTL_RESET}};
      csr_q        <= {2{tmrb_pkg::CSR_RESET}};
      rdData_q     <= 16'h0000;
      irqB_q       <= 2'h0;
      irqA_q       <= 2'h0;
      irqOv_q      <= 2'h0;
      tcbWritten_q <= 1'b0;
    end else begin
      tcb_q        <= tcb_d;
      ctl_q        <= ctl_d;
      csr_q        <= csr_d;
      rdData_q     <= rdData_d;
      irqB_q       <= irqB_d;
      irqA_q       <= irqA_d;
      irqOv_q      <= irqOv_d;
      tcbWritten_q <= tcbWritten_d;
    end
  end

  assign regRdData      = rdData_q;
  assign timerOutputPin = pinLevel;
  assign matchBIrq      = irqB_q;
  assign matchAIrq      = irqA_q;
  assign overflowIrq    = irqOv_q;

  for (genvar l = 0; l < 2; l++) begin : g_sel
    assign counterClockSelect[l] =
      ctl_q[l][tmrb_pkg::CTL_CKS_LSB +: tmrb_pkg::CTL_CKS_WIDTH]; // [RQ6]
    assign counterClearSelect[l] =
      ctl_q[l][tmrb_pkg::CTL_CLR_LSB +: tmrb_pkg::CTL_CLR_WIDTH]; // [RQ6]
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence wordWriteTcb;
    regWrite && (regAddr == tmrb_pkg::ADDR_TCB) && (regByteEn == 2'h3);
  endsequence

  sequence readTcb;
    regRead && (regAddr == tmrb_pkg::ADDR_TCB);
  endsequence

  sequence equalLane0;
    (timerCounterValue[7:0] == tcb_q[0]) && !tcbWrite[0];
  endsequence

  wordWrite_a : assert property (wordWriteTcb |=> tcb_q == $past(regWrData)) // [RQ1]
    else $error("word write to constant B not stored");

  wordRead_a : assert property (readTcb |=> regRdData == $past(tcb_q)) // [RQ1]
    else $error("constant B read data wrong");

  flagAfterEqual_a : assert property ( // [RQ2]
    equalLane0 ##1 matchB[0] |=> csr_q[0][tmrb_pkg::CSR_FLAG_B])
    else $error("match B flag not set after equality");

  writeNoFlag_a : assert property ( // [RQ3]
    tcbWrite[0] && !matchB[0] && !csr_q[0][tmrb_pkg::CSR_FLAG_B]
    |=> ##1 !csr_q[0][tmrb_pkg::CSR_FLAG_B])
    else $error("flag set by compare during a constant B write");

  resetValue_a : assert property (!tcbWritten_q |-> tcb_q == {2{tmrb_pkg::TCB_RESET}}) // [RQ5]
    else $error("constant B not all ones before first write");

  ctlSelect_a : assert property ( // [RQ6]
    regWrite && (regAddr == tmrb_pkg::ADDR_CTL) && regByteEn[1]
    |=> counterClockSelect[1] == $past(regWrData[10:8])
      && counterClearSelect[1] == $past(regWrData[12:11]))
    else $error("clock or clear select not taken from control write");

  irqB_a : assert property ( // [RQ7]
    csr_q[0][tmrb_pkg::CSR_FLAG_B] && ctl_q[0][tmrb_pkg::CTL_IE_B] |-> matchBIrq[0])
    else $error("match B request missing with flag and enable set");

  irqBOff_a : assert property ( // [RQ7] [RQ10]
    !ctl_q[1][tmrb_pkg::CTL_IE_B] |-> !matchBIrq[1])
    else $error("match B request raised while disabled");

  irqA_a : assert property ( // [RQ8]
    matchAEvent[0] && ctl_d[0][tmrb_pkg::CTL_IE_A] |=> matchAIrq[0])
    else $error("match A request missing after event");

  irqOv_a : assert property ( // [RQ9]
    overflowEvent[1] && ctl_d[1][tmrb_pkg::CTL_IE_OV]
    |=> overflowIrq[1] ##1 (overflowIrq[1] || $past(regWrite)))
    else $error("overflow request missing after event");

  irqHold_a : assert property ( // [RQ10]
    matchAIrq[1] && !regWrite |=> matchAIrq[1])
    else $error("match A request dropped without a write");

  setWins_a : assert property ( // [RQ2]
    matchB[0] && regWrite && (regAddr == tmrb_pkg::ADDR_CSR) && regByteEn[0]
    |=> csr_q[0][tmrb_pkg::CSR_FLAG_B])
    else $error("clearing write beat a match B set");

  readIdle_a : assert property (!regRead |=> regRdData == 16'h0000) // [RQ1]
    else $error("read data not zero outside a read answer");

  readCtl_a : assert property ( // [RQ6]
    regRead && (regAddr == tmrb_pkg::ADDR_CTL) |=> regRdData == $past(ctl_q))
    else $error("control read data wrong");

  readCsr_a : assert property ( // [RQ2]
    regRead && (regAddr == tmrb_pkg::ADDR_CSR) |=> regRdData == $past(csr_q))
    else $error("control/status read data wrong");

  readUnmapped_a : assert property ( // [RQ1]
    regRead && (regAddr == 2'h3) |=> regRdData == 16'h0000)
    else $error("unmapped read returned data");

  byteWriteKeep_a : assert property ( // [RQ1]
    regWrite && (regAddr == tmrb_pkg::ADDR_TCB) && (regByteEn == 2'h2)
    |=> tcb_q[0] == $past(tcb_q[0]) && tcb_q[1] == $past(regWrData[15:8]))
    else $error("byte write to constant B touched the other lane");

  tcbHold_a : assert property (!regWrite |=> $stable(tcb_q)) // [RQ1]
    else $error("constant B changed without a write");

  sequence equalLane1;
    (timerCounterValue[15:8] == tcb_q[1]) && !tcbWrite[1];
  endsequence

  flagHigh_a : assert property ( // [RQ2]
    equalLane1 ##1 matchB[1] |=> csr_q[1][tmrb_pkg::CSR_FLAG_B])
    else $error("lane 1 match B flag not set after equality");

  // Clear only counts when no match lands in the same cycle
  sequence clearFlagLane0;
    regWrite && (regAddr == tmrb_pkg::ADDR_CSR) && regByteEn[0] && !regWrData[7];
  endsequence

  flagClear_a : assert property ( // [RQ2]
    (clearFlagLane0 ##0 !matchB[0]) |=> !csr_q[0][tmrb_pkg::CSR_FLAG_B])
    else $error("match B flag not cleared by a zero write");

  flagSticky_a : assert property ( // [RQ2]
    csr_q[1][tmrb_pkg::CSR_FLAG_B] && !regWrite |=> csr_q[1][tmrb_pkg::CSR_FLAG_B])
    else $error("match B flag dropped without a write");

  flagRise_a : assert property ( // [RQ2]
    !csr_q[0][tmrb_pkg::CSR_FLAG_B] && !matchB[0] |=> !csr_q[0][tmrb_pkg::CSR_FLAG_B])
    else $error("match B flag set without a match");

  irqBOffLow_a : assert property ( // [RQ7]
    !ctl_q[0][tmrb_pkg::CTL_IE_B] |-> !matchBIrq[0])
    else $error("lane 0 match B request raised while disabled");

  irqBRise_a : assert property ( // [RQ7]
    matchB[1] && ctl_d[1][tmrb_pkg::CTL_IE_B] |=> matchBIrq[1])
    else $error("match B request missing after a match");

  irqAOff_a : assert property ( // [RQ8]
    !ctl_q[1][tmrb_pkg::CTL_IE_A] |-> !matchAIrq[1])
    else $error("match A request raised while disabled");

  irqOvOff_a : assert property ( // [RQ9]
    !ctl_q[0][tmrb_pkg::CTL_IE_OV] |-> !overflowIrq[0])
    else $error("overflow request raised while disabled");

  irqAFlag_a : assert property ( // [RQ10]
    matchAIrq[0] |-> csr_q[0][tmrb_pkg::CSR_FLAG_A])
    else $error("match A request without its flag");

  irqOvFlag_a : assert property ( // [RQ10]
    overflowIrq[1] |-> csr_q[1][tmrb_pkg::CSR_FLAG_OV])
    else $error("overflow request without its flag");

  ctlSelectLow_a : assert property ( // [RQ6]
    regWrite && (regAddr == tmrb_pkg::ADDR_CTL) && regByteEn[0]
    |=> counterClockSelect[0] == $past(regWrData[2:0])
      && counterClearSelect[0] == $past(regWrData[4:3]))
    else $error("lane 0 clock or clear select not taken from control write");

endmodule : tmrb_top

// >>> bench/tmrb_top_test.sv
// Testbench: register access, compare B, output pin and interrupt gating
`timescale 1ns/100ps
module tmrb_top_test;
  logic              clk;
  logic              resetn;
  logic [1:0]        regAddr;
  logic [1:0]        regByteEn;
  logic [15:0]       regWrData;
  logic              regWrite;
  logic              regRead;
  logic [15:0]       regRdData;
  logic [15:0]       timerCounterValue;
  logic [1:0]        matchAEvent;
  logic [1:0]        overflowEvent;
  logic [1:0]        timerOutputPin;
  logic [1:0][2:0]   counterClockSelect;
  logic [1:0][1:0]   counterClearSelect;
  logic [1:0]        matchBIrq;
  logic [1:0]        matchAIrq;
  logic [1:0]        overflowIrq;
  int                errors;
  int                samplesChecked;

  tmrb_top tmrb_top_i (
    .clk                (clk),
    .resetn             (resetn),
    .regAddr            (regAddr),
    .regByteEn          (regByteEn),
    .regWrData          (regWrData),
    .regWrite           (regWrite),
    .regRead            (regRead),
    .regRdData          (regRdData),
    .timerCounterValue  (timerCounterValue),
    .matchAEvent        (matchAEvent),
    .overflowEvent      (overflowEvent),
    .timerOutputPin     (timerOutputPin),
    .counterClockSelect (counterClockSelect),
    .counterClearSelect (counterClearSelect),
    .matchBIrq          (matchBIrq),
    .matchAIrq          (matchAIrq),
    .overflowIrq        (overflowIrq)
  );

  always #5 clk = ~clk;

  task automatic close_out();
    $display("Comparisons %0d, errors %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic write_reg(input logic [1:0] addr, input logic [1:0] be, input logic [15:0] data);
    @(posedge clk);
    regWrite  <= 1'b1;
    regAddr   <= addr;
    regByteEn <= be;
    regWrData <= data;
    @(posedge clk);
    regWrite  <= 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [1:0] addr, input logic [15:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= addr;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    check_word(regRdData, exp);
  endtask : read_reg

  // One-cycle counter value, then idle long enough for flag, irq and pin to settle
  task automatic pulse_counter(input logic [15:0] val);
    @(posedge clk);
    timerCounterValue <= val;
    @(posedge clk);
    timerCounterValue <= 16'h0000;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse_counter

  task automatic test_reset_values();
    read_reg(tmrb_pkg::ADDR_TCB, 16'hFFFF);
    read_reg(tmrb_pkg::ADDR_CTL, 16'h0000);
    read_reg(tmrb_pkg::ADDR_CSR, 16'h0000);
    check_word({8'h00, timerOutputPin, matchBIrq, matchAIrq, overflowIrq}, 16'h0000);
  endtask : test_reset_values

  task automatic test_registers();
    write_reg(tmrb_pkg::ADDR_CTL, 2'h3, 16'h1F05);
    read_reg(tmrb_pkg::ADDR_CTL, 16'h1F05);
    check_word({10'h000, counterClockSelect}, 16'h003D);
    check_word({12'h000, counterClearSelect}, 16'h000C);
    write_reg(tmrb_pkg::ADDR_TCB, 2'h2, 16'h1234);
    read_reg(tmrb_pkg::ADDR_TCB, 16'h12FF);
    write_reg(tmrb_pkg::ADDR_TCB, 2'h3, 16'h3456);
    read_reg(tmrb_pkg::ADDR_TCB, 16'h3456);
    write_reg(2'h3, 2'h3, 16'hA5A5);
    read_reg(2'h3, 16'h0000);
  endtask : test_registers

  task automatic test_compare_b();
    write_reg(tmrb_pkg::ADDR_CSR, 2'h3, 16'h0201);
    write_reg(tmrb_pkg::ADDR_CTL, 2'h3, 16'h8000);
    pulse_counter(16'h3456);
    check_word({14'h0000, timerOutputPin}, 16'h0002);
    check_word({14'h0000, matchBIrq}, 16'h0002);
    read_reg(tmrb_pkg::ADDR_CSR, 16'h8281);
    write_reg(tmrb_pkg::ADDR_CSR, 2'h3, 16'h0203);
    repeat (2) @(posedge clk);
    #1;
    check_word({14'h0000, matchBIrq}, 16'h0000);
    pulse_counter(16'h3456);
    // Lane 1 holds high, lane 0 toggles from low
    check_word({14'h0000, timerOutputPin}, 16'h0003);
    check_word({14'h0000, matchBIrq}, 16'h0002);
  endtask : test_compare_b

  // Clearing write lands in the cycle of a match, so both flags must survive
  task automatic test_set_wins();
    @(posedge clk);
    timerCounterValue <= 16'h3456;
    @(posedge clk);
    timerCounterValue <= 16'h0000;
    regWrite          <= 1'b1;
    regAddr           <= tmrb_pkg::ADDR_CSR;
    regByteEn         <= 2'h3;
    regWrData         <= 16'h0000;
    @(posedge clk);
    regWrite          <= 1'b0;
    read_reg(tmrb_pkg::ADDR_CSR, 16'h8080);
  endtask : test_set_wins

  // Counter equals the old constant only in the write cycle, so no flag may appear
  task automatic test_write_suppress();
    write_reg(tmrb_pkg::ADDR_CSR, 2'h3, 16'h0000);
    @(posedge clk);
    regWrite          <= 1'b1;
    regAddr           <= tmrb_pkg::ADDR_TCB;
    regByteEn         <= 2'h3;
    regWrData         <= 16'h7878;
    timerCounterValue <= 16'h3456;
    @(posedge clk);
    regWrite          <= 1'b0;
    timerCounterValue <= 16'h0000;
    repeat (3) @(posedge clk);
    read_reg(tmrb_pkg::ADDR_CSR, 16'h0000);
    check_word({14'h0000, matchBIrq}, 16'h0000);
  endtask : test_write_suppress

  task automatic test_a_and_overflow();
    write_reg(tmrb_pkg::ADDR_CTL, 2'h3, 16'h6060);
    @(posedge clk);
    matchAEvent   <= 2'h3;
    overflowEvent <= 2'h2;
    @(posedge clk);
    matchAEvent   <= 2'h0;
    overflowEvent <= 2'h0;
    repeat (2) @(posedge clk);
    #1;
    check_word({14'h0000, matchAIrq}, 16'h0003);
    check_word({14'h0000, overflowIrq}, 16'h0002);
    read_reg(tmrb_pkg::ADDR_CSR, 16'h6040);
    write_reg(tmrb_pkg::ADDR_CTL, 2'h3, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    check_word({12'h000, matchAIrq, overflowIrq}, 16'h0000);
    write_reg(tmrb_pkg::ADDR_CTL, 2'h3, 16'h6060);
    repeat (2) @(posedge clk);
    #1;
    check_word({12'h000, matchAIrq, overflowIrq}, 16'h000E);
    write_reg(tmrb_pkg::ADDR_CSR, 2'h3, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    check_word({12'h000, matchAIrq, overflowIrq}, 16'h0000);
  endtask : test_a_and_overflow

  // Whole sequence needs under a hundred cycles; the margin is generous
  initial begin
    #20000;
    errors++;
    close_out();
  end

  initial begin
    clk               = 1'b0;
    resetn            = 1'b0;
    regAddr           = 2'h0;
    regByteEn         = 2'h0;
    regWrData         = 16'h0000;
    regWrite          = 1'b0;
    regRead           = 1'b0;
    timerCounterValue = 16'h0000;
    matchAEvent       = 2'h0;
    overflowEvent     = 2'h0;
    errors            = 0;
    samplesChecked    = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    test_reset_values();
    test_registers();
    test_compare_b();
    test_set_wins();
    test_write_suppress();
    test_a_and_overflow();
    close_out();
  end
endmodule : tmrb_top_test
